// file: src/pfi_route.v
// programmable function terminal routing for counters and timing engines
// assumes all inputs synchronous to sys_clk_i; pins resolved outside from the enables
`timescale 1ns/1ps
`default_nettype none
`include "pfi_route_regs.vh"
module programmable_function_pin_routing #(
    parameter NUM_TERM = `TERM_NUM
) (
    // clock and reset
    input  wire                  sys_clk_i,
    input  wire                  rst_n_i,
    input  wire                  clk_en_i,
    // terminal pins
    input  wire [NUM_TERM-1:0]   term_in_i,
    output reg  [NUM_TERM-1:0]   term_out_o,
    output reg  [NUM_TERM-1:0]   term_oe_o,
    // configuration
    input  wire [NUM_TERM-1:0]   term_dir_out_i,
    input  wire                  cfg_load_i,
    input  wire [`TERM_SEL_W-1:0] counter0_source_sel_i,
    input  wire [`TERM_SEL_W-1:0] counter0_gate_sel_i,
    input  wire [`TERM_SEL_W-1:0] counter1_source_sel_i,
    input  wire [`TERM_SEL_W-1:0] counter1_gate_sel_i,
    input  wire [`TERM_SEL_W-1:0] wave_start_sel_i,
    input  wire [`TRIG_RT_W-1:0] trig_route_i,
    input  wire                  ctr0_pin_dir_out_i,
    // internal sources
    input  wire                  counter0_src_int_i,
    input  wire                  counter0_gate_int_i,
    input  wire                  counter1_src_int_i,
    input  wire                  counter1_gate_int_i,
    input  wire                  wave_start_int_i,
    input  wire                  wave_out_sample_clock_i,
    input  wire                  acq_sample_clock_i,
    input  wire                  counter0_internal_out_i,
    input  wire                  counter1_internal_out_i,
    input  wire                  freq_gen_i,
    // counter 0 output pin
    input  wire                  ctr0_pin_in_i,
    output reg                   ctr0_pin_out_o,
    output reg                   ctr0_pin_oe_o,
    // dedicated outputs
    output reg                   ctr1_pin_out_o,
    output reg                   freq_gen_out_pin_o,
    // routed signals toward counters and timing engines
    output reg                   counter0_source_o,
    output reg                   counter0_gate_o,
    output reg                   counter1_source_o,
    output reg                   counter1_gate_o,
    output reg                   wave_out_start_trigger_o,
    output reg                   trig_bus_o,
    output reg                   trig_bus_oe_o
);
    // held configuration
    reg  [`TERM_SEL_W-1:0] c0s_r;
    reg  [`TERM_SEL_W-1:0] c0g_r;
    reg  [`TERM_SEL_W-1:0] c1s_r;
    reg  [`TERM_SEL_W-1:0] c1g_r;
    reg  [`TERM_SEL_W-1:0] wst_r;
    reg  [`TRIG_RT_W-1:0]  trt_r;
    reg  [NUM_TERM-1:0]    dir_r;
    reg                    c0dir_r;
    // selector results
    wire                   c0s_w;
    wire                   c0g_w;
    wire                   c1s_w;
    wire                   c1g_w;
    wire                   wst_w;
    // next values of the registered outputs
    reg  [NUM_TERM-1:0]    out_nxt;
    reg                    trig_nxt;
    reg                    trig_oe_nxt;
    // input paths after the own-drive mask
    reg  [NUM_TERM-1:0]    term_rx;
    wire                   ctr0_rx_w;
    integer                i;

    // input buffers are gated off for driven pins so a driven pin never feeds back
    function rx_bit;
        input level;
        input drive;
        begin
            rx_bit = level & ~drive;
        end
    endfunction

    always @* begin
        term_rx = {NUM_TERM{1'b0}};
        for (i = 0; i < NUM_TERM; i = i + 1) begin
            term_rx[i] = rx_bit(term_in_i[i], dir_r[i]);
        end
    end

    assign ctr0_rx_w = rx_bit(ctr0_pin_in_i, c0dir_r);

    // selections held so routing only changes on an explicit load
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            c0s_r   <= `TERM_DEF_CTR0_SRC;
            c0g_r   <= `TERM_DEF_CTR0_GATE;
            c1s_r   <= `TERM_DEF_CTR1_SRC;
            c1g_r   <= `TERM_DEF_CTR1_GATE;
            wst_r   <= `TERM_DEF_WAVE_START;
            trt_r   <= `TRIG_RT_NONE;
            dir_r   <= `TERM_DIR_RESET;
            c0dir_r <= 1'b1;
        end else if (clk_en_i && cfg_load_i) begin
            c0s_r   <= counter0_source_sel_i;
            c0g_r   <= counter0_gate_sel_i;
            c1s_r   <= counter1_source_sel_i;
            c1g_r   <= counter1_gate_sel_i;
            wst_r   <= wave_start_sel_i;
            trt_r   <= trig_route_i;
            dir_r   <= term_dir_out_i;
            c0dir_r <= ctr0_pin_dir_out_i;
        end
    end

    // one selector per counter and wave-start line; all see the same masked terminal inputs
    term_sel_mux #(
        .NUM_TERM   (NUM_TERM)
    ) u_c0s (
        .sel_i      (c0s_r),
        .term_in_i  (term_rx),
        .internal_i (counter0_src_int_i),
        .sel_o      (c0s_w)
    );

    term_sel_mux #(
        .NUM_TERM   (NUM_TERM)
    ) u_c0g (
        .sel_i      (c0g_r),
        .term_in_i  (term_rx),
        .internal_i (counter0_gate_int_i),
        .sel_o      (c0g_w)
    );

    term_sel_mux #(
        .NUM_TERM   (NUM_TERM)
    ) u_c1s (
        .sel_i      (c1s_r),
        .term_in_i  (term_rx),
        .internal_i (counter1_src_int_i),
        .sel_o      (c1s_w)
    );

    term_sel_mux #(
        .NUM_TERM   (NUM_TERM)
    ) u_c1g (
        .sel_i      (c1g_r),
        .term_in_i  (term_rx),
        .internal_i (counter1_gate_int_i),
        .sel_o      (c1g_w)
    );

    term_sel_mux #(
        .NUM_TERM   (NUM_TERM)
    ) u_wst (
        .sel_i      (wst_r),
        .term_in_i  (term_rx),
        .internal_i (wave_start_int_i),
        .sel_o      (wst_w)
    );

    // terminal output values; terminals 0..2 have no output function here
    always @* begin
        out_nxt                       = {NUM_TERM{1'b0}};
        out_nxt[`TERM_POS_CTR1_SRC]   = c1s_w;
        out_nxt[`TERM_POS_CTR1_GATE]  = c1g_w;
        out_nxt[`TERM_POS_WAVE_CLK]   = wave_out_sample_clock_i;
        out_nxt[`TERM_POS_WAVE_START] = wst_w;
        out_nxt[`TERM_POS_ACQ_CLK]    = acq_sample_clock_i;
        out_nxt[`TERM_POS_CTR0_SRC]   = c0s_w;
        out_nxt[`TERM_POS_CTR0_GATE]  = c0g_w;
    end

    // direct trigger bus paths bypass the counters entirely
    always @* begin
        trig_oe_nxt = (trt_r != `TRIG_RT_NONE);
        case (trt_r)
            `TRIG_RT_TERM8:    trig_nxt = term_rx[`TERM_POS_CTR0_SRC];
            `TRIG_RT_TERM9:    trig_nxt = term_rx[`TERM_POS_CTR0_GATE];
            `TRIG_RT_CTR0_PIN: trig_nxt = ctr0_rx_w;
            default:           trig_nxt = 1'b0;
        endcase
    end

    // everything registered: one cycle of latency through the router
    always @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            term_out_o               <= {NUM_TERM{1'b0}};
            term_oe_o                <= {NUM_TERM{1'b0}};
            ctr0_pin_out_o           <= 1'b0;
            ctr0_pin_oe_o            <= 1'b0;
            ctr1_pin_out_o           <= 1'b0;
            freq_gen_out_pin_o       <= 1'b0;
            counter0_source_o        <= 1'b0;
            counter0_gate_o          <= 1'b0;
            counter1_source_o        <= 1'b0;
            counter1_gate_o          <= 1'b0;
            wave_out_start_trigger_o <= 1'b0;
            trig_bus_o               <= 1'b0;
            trig_bus_oe_o            <= 1'b0;
        end else if (clk_en_i) begin
            term_out_o               <= out_nxt & dir_r;
            term_oe_o                <= dir_r;
            ctr0_pin_out_o           <= counter0_internal_out_i & c0dir_r;
            ctr0_pin_oe_o            <= c0dir_r;
            ctr1_pin_out_o           <= counter1_internal_out_i;
            freq_gen_out_pin_o       <= freq_gen_i;
            counter0_source_o        <= c0s_w;
            counter0_gate_o          <= c0g_w;
            counter1_source_o        <= c1s_w;
            counter1_gate_o          <= c1g_w;
            wave_out_start_trigger_o <= wst_w;
            trig_bus_o               <= trig_nxt;
            trig_bus_oe_o            <= trig_oe_nxt;
        end
    end
endmodule
`default_nettype wire

// file: src/pfi_route_regs.vh
// constants for the programmable function terminal routing block
// assumes terminals are numbered 0..9 and selects index a terminal or an internal line
`ifndef PIN_ROUTE_REGS_VH
`define PIN_ROUTE_REGS_VH

`define TERM_NUM            10
`define TERM_SEL_W          4
// select codes 0..9 pick a terminal; 4'hf picks the internal line
`define TERM_SEL_INTERNAL   4'hf
`define TERM_DEF_CTR1_SRC   4'h3
`define TERM_DEF_CTR1_GATE  4'h4
`define TERM_DEF_WAVE_START 4'h6
`define TERM_DEF_CTR0_SRC   4'h8
`define TERM_DEF_CTR0_GATE  4'h9
`define TERM_DIR_RESET      10'h000
// terminal positions that carry an output function
`define TERM_POS_CTR1_SRC   3
`define TERM_POS_CTR1_GATE  4
`define TERM_POS_WAVE_CLK   5
`define TERM_POS_WAVE_START 6
`define TERM_POS_ACQ_CLK    7
`define TERM_POS_CTR0_SRC   8
`define TERM_POS_CTR0_GATE  9
// trigger bus route codes
`define TRIG_RT_W          2
`define TRIG_RT_NONE       2'h0
`define TRIG_RT_TERM8      2'h1
`define TRIG_RT_TERM9      2'h2
`define TRIG_RT_CTR0_PIN   2'h3

`endif

// file: src/pfi_sel_mux.v
// one input selector: picks a terminal input or the internal line
// assumes terminal inputs are already synchronous to the clock
`timescale 1ns/1ps
`default_nettype none
`include "pfi_route_regs.vh"
module term_sel_mux #(
    parameter NUM_TERM = `TERM_NUM
) (
    // selection
    input  wire [`TERM_SEL_W-1:0] sel_i,
    input  wire [NUM_TERM-1:0]   term_in_i,
    input  wire                  internal_i,
    // result
    output reg                   sel_o
);
    always @* begin
        if (sel_i == `TERM_SEL_INTERNAL) begin
            sel_o = internal_i;
        end else if (sel_i < NUM_TERM) begin
            sel_o = term_in_i[sel_i];
        end else begin
            sel_o = 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: dv/pfi_route_props.sv
// checker for the terminal routing block
// assumes one clock and an async active-low reset
`timescale 1ns/1ps
`default_nettype none
module programmable_function_pin_routing_props #(parameter NUM_TERM = 10) (
    // clock, reset, enable
    input wire logic                sys_clk_i,
    input wire logic                rst_n_i,
    input wire logic                clk_en_i,
    // internal levels and pins
    input wire logic                wave_out_sample_clock_i,
    input wire logic                acq_sample_clock_i,
    input wire logic                counter0_internal_out_i,
    input wire logic                counter1_internal_out_i,
    input wire logic                freq_gen_i,
    input wire logic [NUM_TERM-1:0] term_out_o,
    input wire logic [NUM_TERM-1:0] term_oe_o,
    input wire logic                ctr0_pin_out_o,
    input wire logic                ctr0_pin_oe_o,
    input wire logic                ctr1_pin_out_o,
    input wire logic                freq_gen_out_pin_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    // direction must hold across the edge, else the mirror is not yet valid
    sequence s_drv(b); clk_en_i && b ##1 b; endsequence
    property p_term5; s_drv(term_oe_o[5]) |-> term_out_o[5] == $past(wave_out_sample_clock_i);
    endproperty
    property p_term7; s_drv(term_oe_o[7]) |-> term_out_o[7] == $past(acq_sample_clock_i);
    endproperty
    property p_ctr0_pin; s_drv(ctr0_pin_oe_o) |-> ctr0_pin_out_o == $past(counter0_internal_out_i);
    endproperty
    property p_ctr1_pin; clk_en_i |=> ctr1_pin_out_o == $past(counter1_internal_out_i); endproperty
    property p_freq; clk_en_i |=> freq_gen_out_pin_o == $past(freq_gen_i); endproperty
    property p_oe_reset; disable iff (1'b0) !rst_n_i |-> term_oe_o == 0 && !ctr0_pin_oe_o;
    endproperty
    property p_masked; (term_out_o & ~term_oe_o) == 0; endproperty
    property p_freeze; !clk_en_i |=> $stable(term_out_o) && $stable(term_oe_o); endproperty
    a_term5:    assert property (p_term5) else $error("terminal 5 mirror wrong");
    a_term7:    assert property (p_term7) else $error("terminal 7 mirror wrong");
    a_ctr0_pin: assert property (p_ctr0_pin) else $error("counter 0 pin wrong");
    a_ctr1_pin: assert property (p_ctr1_pin) else $error("counter 1 pin wrong");
    a_freq:     assert property (p_freq) else $error("frequency pin wrong");
    a_oe_reset: assert property (p_oe_reset) else $error("driving in reset");
    a_masked:   assert property (p_masked) else $error("undriven terminal not 0");
    a_freeze:   assert property (p_freeze) else $error("state moved while disabled");
endmodule
bind programmable_function_pin_routing programmable_function_pin_routing_props
    #(.NUM_TERM(NUM_TERM)) i_programmable_function_pin_routing_props (.sys_clk_i,
    .rst_n_i, .clk_en_i, .wave_out_sample_clock_i, .acq_sample_clock_i,
    .counter0_internal_out_i, .counter1_internal_out_i, .freq_gen_i, .term_out_o,
    .term_oe_o, .ctr0_pin_out_o, .ctr0_pin_oe_o, .ctr1_pin_out_o, .freq_gen_out_pin_o);
`default_nettype wire

// file: dv/pfi_ext_equip.sv
// external equipment on the connector side
// assumes the bench sets drive values just after the clock edge
`timescale 1ns/1ps
`default_nettype none
module term_ext_equip (
    // from the block
    input  wire logic [9:0] term_out_i,
    input  wire logic [9:0] term_oe_i,
    input  wire logic       ctr0_out_i,
    input  wire logic       ctr0_oe_i,
    // equipment drive and resolved pins
    input  wire logic [9:0] drv_i,
    input  wire logic       ctr0_drv_i,
    output wire logic [9:0] pin_o,
    output wire logic       ctr0_pin_o
);
    // equipment backs off wherever the block drives, so no contention
    assign pin_o      = (term_oe_i & term_out_i) | (~term_oe_i & drv_i);
    assign ctr0_pin_o = ctr0_oe_i ? ctr0_out_i : ctr0_drv_i;
endmodule
`default_nettype wire

// file: dv/test_pfi_route.sv
// self-checking bench for the terminal routing block
// assumes the equipment model drives every input terminal
`timescale 1ns/1ps
`default_nettype none
module test_programmable_function_pin_routing;
    logic       sys_clk_i, rst_n_i, clk_en_i, cfg_load_i, c0dir, c0drv, c0pin, c0o, c0oe;
    logic       c1o, fo, c0s, c0g, c1s, c1g, wst, tb, tboe;
    logic [9:0] dir, drv, intl, pin, term_out_o, term_oe_o;
    logic [3:0] s0, s1, s2, s3, s4;
    logic [1:0] rt;
    int         n_errors = 0, n_compared = 0;
    programmable_function_pin_routing i_programmable_function_pin_routing (.sys_clk_i,
        .rst_n_i, .clk_en_i, .term_in_i(pin), .term_out_o,
        .term_oe_o, .term_dir_out_i(dir), .cfg_load_i, .counter0_source_sel_i(s0),
        .counter0_gate_sel_i(s1), .counter1_source_sel_i(s2), .counter1_gate_sel_i(s3),
        .wave_start_sel_i(s4), .trig_route_i(rt), .ctr0_pin_dir_out_i(c0dir),
        .counter0_src_int_i(intl[9]), .counter0_gate_int_i(intl[8]),
        .counter1_src_int_i(intl[7]), .counter1_gate_int_i(intl[6]),
        .wave_start_int_i(intl[5]), .wave_out_sample_clock_i(intl[4]),
        .acq_sample_clock_i(intl[3]), .counter0_internal_out_i(intl[2]),
        .counter1_internal_out_i(intl[1]), .freq_gen_i(intl[0]), .ctr0_pin_in_i(c0pin),
        .ctr0_pin_out_o(c0o), .ctr0_pin_oe_o(c0oe), .ctr1_pin_out_o(c1o),
        .freq_gen_out_pin_o(fo), .counter0_source_o(c0s), .counter0_gate_o(c0g),
        .counter1_source_o(c1s), .counter1_gate_o(c1g), .wave_out_start_trigger_o(wst),
        .trig_bus_o(tb), .trig_bus_oe_o(tboe));
    term_ext_equip i_term_ext_equip (.term_out_i(term_out_o), .term_oe_i(term_oe_o),
        .ctr0_out_i(c0o), .ctr0_oe_i(c0oe), .drv_i(drv), .ctr0_drv_i(c0drv), .pin_o(pin),
        .ctr0_pin_o(c0pin));
    task automatic step(int n = 1);
        repeat (n) @(posedge sys_clk_i);
        #2;
    endtask
    task automatic chk(input logic [9:0] e, input logic [9:0] g);
        n_compared++;
        if (g !== e) begin
            n_errors++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic results;
        if (n_errors == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // outputs follow one edge after the capture edge
    task automatic cfg(input logic [9:0] d, input logic [3:0] a, b, c, e, f,
                       input logic [1:0] r, input logic p);
        {dir, s0, s1, s2, s3, s4, rt, c0dir, cfg_load_i} = {d, a, b, c, e, f, r, p, 1'b1};
        step();
        cfg_load_i = 0;
        step();
    endtask
    task automatic t_defaults(input logic [9:0] v);
        drv = v;
        step();
        chk({v[8], v[9], v[3], v[4], v[6]}, {c0s, c0g, c1s, c1g, wst});
        chk(0, term_oe_o);
        chk(2'b01, {tboe, c0oe});
    endtask
    // terminals 0..2 and 7 as selector inputs; code 4'ha is refused and gives 0
    task automatic t_select;
        cfg(10'h000, 4'h0, 4'h1, 4'h2, 4'h7, 4'ha, 2'h0, 1'b1);
        intl = 10'h3ff;
        for (int k = 0; k < 2; k++) begin
            drv = k ? 10'h3fa : 10'h005;
            step();
            chk(k ? 10'h0a : 10'h14, {c0s, c0g, c1s, c1g, wst});
        end
    endtask
    // mid-run reset must drop every drive and every routed level
    task automatic t_reset;
        rst_n_i = 0;
        step();
        chk(0, term_oe_o);
        chk(0, {tboe, c0oe, c0s, c0g, c1s, c1g, wst, tb, c0o, c1o});
        rst_n_i = 1;
    endtask
    task automatic t_mirror;
        // counter 1 source picks terminal 8 while it drives: must read 0
        cfg(10'h3f0, 4'hf, 4'hf, 4'h8, 4'hf, 4'hf, 2'h0, 1'b1);
        drv = 10'h3ff;
        for (int k = 0; k < 2; k++) begin
            intl = k ? 10'h192 : 10'h26d;
            step();
            chk(k ? 10'h220 : 10'h1d0, term_out_o);
            chk(10'h3f0, term_oe_o);
            chk(k ? 10'h02 : 10'h15, {c0s, c1s, c0o, c1o, fo});
        end
        clk_en_i = 0;
        intl = 10'h26d;
        step(2);
        chk(10'h220, term_out_o);
        clk_en_i = 1;
    endtask
    task automatic t_trig;
        for (int r = 1; r < 4; r++) begin
            cfg(10'h000, 4'h8, 4'h9, 4'h3, 4'h4, 4'h6, r[1:0], 1'b0);
            drv = (r == 1) ? 10'h100 : (r == 2) ? 10'h200 : 10'h0ff;
            c0drv = r == 3;
            step();
            chk(2'b11, {tboe, tb});
            drv = ~drv;
            c0drv = !c0drv;
            step();
            chk(2'b10, {tboe, tb});
        end
    endtask
    initial begin
        sys_clk_i = 0;
        forever #12.5 sys_clk_i = ~sys_clk_i;
    end
    initial begin
        {rst_n_i, clk_en_i, cfg_load_i, c0dir, c0drv, dir, drv, intl} = 0;
        {s0, s1, s2, s3, s4, rt} = 0;
        repeat (5) @(posedge sys_clk_i);
        #2 rst_n_i = 1;
        clk_en_i = 1;
        step();
        t_defaults(10'h148);
        t_defaults(10'h210);
        t_select();
        t_mirror();
        t_trig();
        t_reset();
        t_defaults(10'h3ff);
        results();
    end
    initial begin
        #100000;
        n_errors++;
        results();
    end
endmodule
`default_nettype wire
